/* rtl/cpu_addr_core.v */
// Register set, instruction queue and operand address generation
`timescale 1ns/10ps
`include "cpu_addr_consts.vh"
module cpu_addr_core #(
  parameter [15:0] VECTOR_ADDR = `VEC_DEFAULT
) (
  // System
  input wire CLK,
  input wire RESETN,
  // Wishbone slave
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [7:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  output reg [31:0] WB_DAT_O,
  output reg WB_ACK_O,
  // Internal memory bus, byte wide
  output reg MEM_REQ,
  output reg MEM_WE,
  output reg [15:0] MEM_ADDR,
  output reg [7:0] MEM_WDATA,
  input wire [7:0] MEM_RDATA,
  input wire MEM_ACK
);

  // ---------------------------------------------
  // States, one-hot
  // ---------------------------------------------
  localparam [12:0] S_VECH = 13'h0001;
  localparam [12:0] S_VECL = 13'h0002;
  localparam [12:0] S_IDLE = 13'h0004;
  localparam [12:0] S_START = 13'h0008;
  localparam [12:0] S_OPC = 13'h0010;
  localparam [12:0] S_POST = 13'h0020;
  localparam [12:0] S_EXT = 13'h0040;
  localparam [12:0] S_EXEC = 13'h0080;
  localparam [12:0] S_PTRH = 13'h0100;
  localparam [12:0] S_PTRL = 13'h0200;
  localparam [12:0] S_PUSHL = 13'h0400;
  localparam [12:0] S_PUSHH = 13'h0800;
  localparam [12:0] S_JUMP = 13'h1000;

  // ---------------------------------------------
  // Programmer-visible registers
  // ---------------------------------------------
  reg [7:0] acc_a; // First accumulator, high half of D
  reg [7:0] acc_b; // Second accumulator, low half of D
  reg [15:0] idx_x; // Index register X
  reg [15:0] idx_y; // Index register Y
  reg [15:0] sp; // Last used stack location
  reg [15:0] pc; // Next code byte to consume
  reg [7:0] flag_register; // S X H I N Z V C

  // ---------------------------------------------
  // Decoder and queue state
  // ---------------------------------------------
  reg [12:0] state;
  reg [15:0] ea; // Effective address result
  reg [15:0] operand; // Inline operand
  reg [7:0] opcode; // Last opcode taken
  reg [7:0] pb; // Indexed postbyte
  reg [15:0] long_address_mode; // Extension bytes, first one high
  reg [1:0] nleft; // Extension bytes still to take
  reg [3:0] mode; // Class of the current opcode
  reg page2; // Second opcode page selected
  reg taken; // Last branch was taken
  reg [7:0] ptr_hi; // High byte of indirect pointer
  reg [15:0] fetch_addr; // Next code byte to prefetch
  reg [7:0] q [0:2]; // Code byte queue, q[0] oldest
  reg [1:0] qcnt; // Valid bytes in queue
  reg mem_busy; // Memory request outstanding
  reg mem_fetch; // Outstanding request is a code fetch
  reg discard; // Drop the fetch that is in flight
  reg dphase; // Data access issued by this state
  reg [31:0] rd_data; // Read mux for the bus

  wire [15:0] acc_d = {acc_a, acc_b}; // [RL1]
  wire [7:0] head = q[0];
  wire bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire bus_wr = bus_req & WB_WE_I;
  wire [7:0] bus_ofs = {WB_ADR_I[7:2], 2'b00};
  wire in_idle = (state == S_IDLE);
  // Queue bytes are consumed by the decode states only
  wire pop = ((state == S_OPC) | (state == S_POST) |
    (state == S_EXT)) & (qcnt != 2'd0);
  // Prefetch pauses while data accesses own the bus
  wire dstate = (state == S_VECH) | (state == S_VECL) |
    (state == S_PTRH) | (state == S_PTRL) |
    (state == S_PUSHL) | (state == S_PUSHH);
  wire fetch_ok = ~dstate & (state != S_JUMP) & ~mem_busy &
    (qcnt != 2'd3);
  wire push = MEM_ACK & mem_busy & mem_fetch & ~discard;
  wire [1:0] wr_idx = qcnt - {1'b0, pop};
  wire data_ack = dphase & MEM_ACK;
  wire redirect = (state == S_JUMP) |
    (bus_wr & in_idle & (bus_ofs == `R_PC));

  // ---------------------------------------------
  // Helper functions
  // ---------------------------------------------
  // Base register for an indexed form
  function [15:0] pick_base;
    input [1:0] rr;
    input [15:0] x;
    input [15:0] y;
    input [15:0] s;
    input [15:0] p;
    begin
      case (rr)
        `RR_X: pick_base = x;
        `RR_Y: pick_base = y;
        `RR_SP: pick_base = s;
        default: pick_base = p;
      endcase
    end
  endfunction

  // Byte-lane merge of a 16-bit register write
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] wd;
    input [1:0] sel;
    begin
      merge16 = {sel[1] ? wd[15:8] : old[15:8],
        sel[0] ? wd[7:0] : old[7:0]};
    end
  endfunction

  // Branch condition on N, Z, V and C only
  function cond_true;
    input [2:0] cc;
    input [7:0] f;
    begin
      case (cc)
        3'd0: cond_true = 1'b1;
        3'd1: cond_true = f[`F_Z];
        3'd2: cond_true = ~f[`F_Z];
        3'd3: cond_true = f[`F_C];
        3'd4: cond_true = ~f[`F_C];
        3'd5: cond_true = f[`F_N];
        3'd6: cond_true = f[`F_V];
        default: cond_true = f[`F_N] ^ f[`F_V];
      endcase
    end
  endfunction

  // ---------------------------------------------
  // Effective address datapath
  // ---------------------------------------------
  reg [1:0] rr; // Selected base register code
  reg [15:0] base; // Selected base value
  reg [15:0] amt; // Auto-modify step
  reg [15:0] next_ea;
  reg [15:0] next_base; // Base after auto-modify
  reg upd; // Base register is written back
  reg indirect; // Pointer must be fetched first
  reg [15:0] d_addr; // Address of the data access
  reg d_we;
  reg [7:0] d_wdata;

  // Address formation for every mode, decided in S_EXEC
  always @* begin
    rr = (pb[`PB_TOP] == `PB_EXTFORM) ? pb[`PB_RR_LO] : pb[`PB_RR_HI];
    // Program counter as base already points past the instruction
    base = pick_base(rr, idx_x, idx_y, sp, pc); // [RL4]
    amt = pb[`PB_SGN4] ? {12'hfff, pb[`PB_N4]} :
      {12'h000, pb[`PB_N4]} + 16'h0001;
    next_ea = ea;
    next_base = base;
    upd = 1'b0;
    indirect = 1'b0;
    case (mode)
      `CL_DIRECT: next_ea = {8'h00, long_address_mode[7:0]}; // [RL14]
      `CL_LONG, `CL_CALL: next_ea = long_address_mode; // [RL15]
      `CL_REL8: next_ea = pc + {{8{long_address_mode[7]}}, long_address_mode[7:0]}; // [RL16]
      `CL_REL16: next_ea = pc + long_address_mode; // [RL16]
      `CL_INDEXED: begin
        if (pb[`PB_TOP] != `PB_EXTFORM && !pb[`PB_AUTO]) begin
          // Short form, -16 to +15
          next_ea = base + {{11{pb[`PB_SGN5]}}, pb[`PB_N5]}; // [RL17]
        end else if (pb[`PB_TOP] != `PB_EXTFORM) begin
          // Auto modify never sees the program counter here
          next_base = base + amt; // [RL18]
          next_ea = pb[`PB_POST] ? base : next_base; // [RL18]
          upd = 1'b1;
        end else if (!pb[`PB_ACCSEL]) begin
          if (!pb[`PB_Z]) begin
            // Sign of the 9-bit offset lives in the postbyte
            next_ea = base + {{8{pb[`PB_S]}}, long_address_mode[7:0]}; // [RL20]
          end else begin
            next_ea = base + long_address_mode; // [RL2] [RL20]
            indirect = pb[`PB_S]; // [RL21]
          end
        end else begin
          // Accumulator offsets are unsigned
          case (pb[`PB_AA])
            `AA_A: next_ea = base + {8'h00, acc_a}; // [RL19]
            `AA_B: next_ea = base + {8'h00, acc_b}; // [RL19]
            `AA_D: next_ea = base + acc_d; // [RL19]
            default: begin
              next_ea = base + acc_d; // [RL21]
              indirect = 1'b1;
            end
          endcase
        end
      end
      default: next_ea = ea;
    endcase
  end

  // Address and data of the access owned by a data state
  always @* begin
    d_we = 1'b0;
    d_wdata = 8'h00;
    case (state)
      S_VECH: d_addr = VECTOR_ADDR; // [RL7]
      S_VECL: d_addr = VECTOR_ADDR + 16'h0001;
      S_PTRH: d_addr = ea; // [RL22]
      S_PTRL: d_addr = ea + 16'h0001; // [RL9]
      S_PUSHL: begin
        // Low byte goes to the higher address
        d_addr = sp - 16'h0001; // [RL8]
        d_we = 1'b1;
        d_wdata = pc[7:0];
      end
      S_PUSHH: begin
        d_addr = sp - 16'h0002; // [RL3] [RL8]
        d_we = 1'b1;
        d_wdata = pc[15:8];
      end
      default: d_addr = 16'h0000;
    endcase
  end

  // Bus read view; core registers sit only here, never in memory
  always @* begin
    case (bus_ofs)
      `R_STAT: rd_data = {24'h000000, mode, 1'b0, taken, page2,
        ~in_idle};
      `R_ACC: rd_data = {16'h0000, acc_d}; // [RL12]
      `R_IX: rd_data = {16'h0000, idx_x};
      `R_IY: rd_data = {16'h0000, idx_y};
      `R_SP: rd_data = {16'h0000, sp};
      `R_PC: rd_data = {16'h0000, pc};
      `R_FLAG: rd_data = {24'h000000, flag_register};
      `R_EA: rd_data = {16'h0000, ea};
      `R_OPND: rd_data = {16'h0000, operand};
      `R_OPC: rd_data = {24'h000000, opcode};
      default: rd_data = 32'h00000000;
    endcase
  end

  // ---------------------------------------------
  // Wishbone answer: one wait state, every access
  // ---------------------------------------------
  always @(posedge CLK) begin
    if (!RESETN) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end else begin
      WB_ACK_O <= bus_req;
      if (bus_req) begin
        WB_DAT_O <= rd_data;
      end
    end
  end

  // ---------------------------------------------
  // Queue, memory port and sequencer
  // ---------------------------------------------
  always @(posedge CLK) begin
    if (!RESETN) begin
      state <= S_VECH;
      acc_a <= 8'h00;
      acc_b <= 8'h00;
      idx_x <= 16'h0000;
      idx_y <= 16'h0000;
      sp <= 16'h0000;
      pc <= 16'h0000;
      flag_register <= `FLAG_RST; // [RL7]
      ea <= 16'h0000;
      operand <= 16'h0000;
      opcode <= 8'h00;
      pb <= 8'h00;
      long_address_mode <= 16'h0000;
      nleft <= 2'd0;
      mode <= `CL_REGONLY;
      page2 <= 1'b0;
      taken <= 1'b0;
      ptr_hi <= 8'h00;
      fetch_addr <= 16'h0000;
      q[0] <= 8'h00;
      q[1] <= 8'h00;
      q[2] <= 8'h00;
      qcnt <= 2'd0;
      mem_busy <= 1'b0;
      mem_fetch <= 1'b0;
      discard <= 1'b0;
      dphase <= 1'b0;
      MEM_REQ <= 1'b0;
      MEM_WE <= 1'b0;
      MEM_ADDR <= 16'h0000;
      MEM_WDATA <= 8'h00;
    end else begin
      // Completion of any outstanding access
      if (mem_busy && MEM_ACK) begin
        mem_busy <= 1'b0;
        MEM_REQ <= 1'b0;
        MEM_WE <= 1'b0;
        discard <= 1'b0;
      end
      // Byte queue: shift on pop, fill behind the survivors
      if (pop) begin
        q[0] <= q[1];
        q[1] <= q[2];
      end
      if (push) begin
        q[wr_idx] <= MEM_RDATA; // [RL10]
      end
      qcnt <= qcnt - {1'b0, pop} + {1'b0, push};
      // Prefetch one byte at a time, any address
      if (fetch_ok) begin
        MEM_REQ <= 1'b1;
        MEM_ADDR <= fetch_addr; // [RL9]
        fetch_addr <= fetch_addr + 16'h0001;
        mem_busy <= 1'b1;
        mem_fetch <= 1'b1;
      end else if (dstate && !mem_busy && !dphase) begin
        MEM_REQ <= 1'b1;
        MEM_WE <= d_we;
        MEM_ADDR <= d_addr;
        MEM_WDATA <= d_wdata;
        mem_busy <= 1'b1;
        mem_fetch <= 1'b0;
        dphase <= 1'b1;
      end
      if (data_ack) begin
        dphase <= 1'b0;
      end
      // Change of flow: empty the queue, drop a fetch in flight
      if (redirect) begin
        fetch_addr <= (state == S_JUMP) ? ea : WB_DAT_I[15:0];
        qcnt <= 2'd0;
        // A fetch launched on this same edge still reads the old address
        discard <= (mem_busy & mem_fetch & ~MEM_ACK) | fetch_ok;
      end
      case (state)
        S_VECH: begin
          if (data_ack) begin
            pc[15:8] <= MEM_RDATA; // [RL7] [RL8]
            state <= S_VECL;
          end
        end
        S_VECL: begin
          if (data_ack) begin
            pc[7:0] <= MEM_RDATA;
            fetch_addr <= {pc[15:8], MEM_RDATA};
            qcnt <= 2'd0;
            state <= S_IDLE;
          end
        end
        S_IDLE: begin
          // Registers load only while the sequencer rests
          if (bus_wr) begin
            case (bus_ofs)
              `R_CTRL: begin
                if (WB_SEL_I[0] && WB_DAT_I[`GO_BIT]) begin
                  page2 <= 1'b0;
                  taken <= 1'b0;
                  state <= S_START;
                end
              end
              `R_ACC: {acc_a, acc_b} <= merge16(acc_d,
                WB_DAT_I[15:0], WB_SEL_I[1:0]);
              `R_IX: idx_x <= merge16(idx_x, WB_DAT_I[15:0],
                WB_SEL_I[1:0]);
              `R_IY: idx_y <= merge16(idx_y, WB_DAT_I[15:0],
                WB_SEL_I[1:0]);
              `R_SP: sp <= merge16(sp, WB_DAT_I[15:0], WB_SEL_I[1:0]);
              `R_PC: pc <= WB_DAT_I[15:0];
              // Half carry is kept for decimal adjust, read by none
              `R_FLAG: begin
                if (WB_SEL_I[0]) begin
                  flag_register <= WB_DAT_I[7:0]; // [RL5] [RL6]
                end
              end
              default: state <= S_IDLE;
            endcase
          end
        end
        S_START: begin
          // Wait for three code bytes before decoding
          if (qcnt == 2'd3) begin
            state <= S_OPC; // [RL10]
          end
        end
        S_OPC: begin
          if (pop) begin
            pc <= pc + 16'h0001; // [RL11]
            if (head == `PAGE2_PREFIX && !page2) begin
              page2 <= 1'b1; // [RL23]
            end else begin
              opcode <= head; // [RL23]
              mode <= head[`OPC_CLASS];
              long_address_mode <= 16'h0000;
              case (head[`OPC_CLASS])
                `CL_INLINE8, `CL_DIRECT, `CL_REL8: begin
                  nleft <= 2'd1;
                  state <= S_EXT;
                end
                `CL_INLINE16, `CL_LONG, `CL_REL16, `CL_CALL: begin
                  nleft <= 2'd2;
                  state <= S_EXT;
                end
                `CL_INDEXED: state <= S_POST;
                // Single-byte instruction ends here
                default: state <= S_IDLE; // [RL11]
              endcase
            end
          end
        end
        S_POST: begin
          if (pop) begin
            pb <= head;
            pc <= pc + 16'h0001;
            if (head[`PB_TOP] == `PB_EXTFORM && !head[`PB_ACCSEL]) begin
              nleft <= head[`PB_Z] ? 2'd2 : 2'd1; // [RL20]
              state <= S_EXT;
            end else begin
              state <= S_EXEC;
            end
          end
        end
        S_EXT: begin
          if (pop) begin
            long_address_mode <= {long_address_mode[7:0], head}; // [RL8] [RL13]
            pc <= pc + 16'h0001;
            nleft <= nleft - 2'd1;
            if (nleft == 2'd1) begin
              state <= S_EXEC;
            end
          end
        end
        S_EXEC: begin
          ea <= next_ea; // [RL2]
          state <= S_IDLE;
          case (mode)
            `CL_INLINE8, `CL_INLINE16: operand <= long_address_mode; // [RL13]
            `CL_REL8, `CL_REL16: begin
              taken <= cond_true(opcode[`OPC_COND],
                flag_register); // [RL5]
              if (cond_true(opcode[`OPC_COND], flag_register)) begin
                state <= S_JUMP;
              end
            end
            `CL_CALL: state <= S_PUSHL; // [RL3]
            `CL_INDEXED: begin
              if (upd) begin
                case (rr)
                  `RR_X: idx_x <= next_base; // [RL18]
                  `RR_Y: idx_y <= next_base;
                  default: sp <= next_base;
                endcase
              end
              if (indirect) begin
                state <= S_PTRH; // [RL21]
              end
            end
            default: state <= S_IDLE;
          endcase
        end
        S_PTRH: begin
          if (data_ack) begin
            ptr_hi <= MEM_RDATA; // [RL22]
            state <= S_PTRL;
          end
        end
        S_PTRL: begin
          if (data_ack) begin
            ea <= {ptr_hi, MEM_RDATA}; // [RL21] [RL22]
            state <= S_IDLE;
          end
        end
        S_PUSHL: begin
          if (data_ack) begin
            state <= S_PUSHH;
          end
        end
        S_PUSHH: begin
          if (data_ack) begin
            sp <= sp - 16'h0002; // [RL3]
            state <= S_JUMP;
          end
        end
        S_JUMP: begin
          pc <= ea; // [RL16]
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule

/* pkg/cpu_addr_consts.vh */
// Constants for the register set and address generation core
`ifndef CPU_ADDR_CONSTS_VH
`define CPU_ADDR_CONSTS_VH
// Overview of operation
// [RL1] Two 8-bit accumulators, first is high byte
// [RL2] Indexed EA is index plus constant or accumulator
// [RL3] Stack pointer marks last used; calls push context; the code pushes only the two-byte return address
// [RL4] Program counter points to next instruction
// [RL5] Flags: H N Z V C, two masks, stop-disable
// [RL6] Half carry serves only decimal adjust
// [RL7] Reset fetches vector, sets masks and stop-disable
// [RL8] Words are stored high byte at lower address
// [RL9] Any byte address; no alignment restriction
// [RL10] Queue holds three code bytes at instruction start
// [RL11] Instructions of any byte length, never padded
// [RL12] Core registers are not in memory space
// [RL13] Immediate operand comes from instruction stream
// [RL14] Direct mode: high address byte is zero
// [RL15] Extended mode carries full 16-bit address
// [RL16] Relative target is offset plus program counter
// [RL17] Short indexed adds 5-bit signed constant
// [RL18] Auto modify by 1 to 8, pre or post
// [RL19] Accumulator offset adds A, B or D
// [RL20] 9-bit offset one byte, 16-bit two bytes
// [RL21] Indirect modes read pointer then use it
// [RL22] Indirect pointer read high byte first
// [RL23] Opcodes 8-bit; prefix 18 selects page two

// ---------------------------------------------
// Register offsets on the Wishbone bus
// ---------------------------------------------
`define R_CTRL 8'h00
`define R_STAT 8'h04
`define R_ACC 8'h08
`define R_IX 8'h0c
`define R_IY 8'h10
`define R_SP 8'h14
`define R_PC 8'h18
`define R_FLAG 8'h1c
`define R_EA 8'h20
`define R_OPND 8'h24
`define R_OPC 8'h28
`define GO_BIT 0

// ---------------------------------------------
// Flag register layout and reset state
// ---------------------------------------------
`define F_C 0
`define F_V 1
`define F_Z 2
`define F_N 3
`define FLAG_RST 8'hd0
`define VEC_DEFAULT 16'hfffe

// ---------------------------------------------
// Opcode fields and instruction classes
// ---------------------------------------------
`define PAGE2_PREFIX 8'h18
`define OPC_CLASS 7:4
`define OPC_COND 2:0
`define CL_REGONLY 4'h0
`define CL_INLINE8 4'h1
`define CL_INLINE16 4'h2
`define CL_DIRECT 4'h3
`define CL_LONG 4'h4
`define CL_REL8 4'h5
`define CL_REL16 4'h6
`define CL_INDEXED 4'h7
`define CL_CALL 4'h8

// ---------------------------------------------
// Indexed postbyte fields
// ---------------------------------------------
`define PB_TOP 7:5
`define PB_EXTFORM 3'b111
`define PB_RR_HI 7:6
`define PB_RR_LO 4:3
`define PB_AUTO 5
`define PB_POST 4
`define PB_N4 3:0
`define PB_SGN4 3
`define PB_N5 4:0
`define PB_SGN5 4
`define PB_ACCSEL 2
`define PB_Z 1
`define PB_S 0
`define PB_AA 1:0
`define AA_A 2'b00
`define AA_B 2'b01
`define AA_D 2'b10
`define RR_X 2'b00
`define RR_Y 2'b01
`define RR_SP 2'b10
`endif

/* sim/cpu_addr_core_checker.sv */
// Port-level assertions for the register set and address core
`timescale 1ns/10ps
module cpu_addr_core_checker #(
  parameter [15:0] VECTOR_ADDR = 16'hfffe
) (
  // System
  input logic CLK,
  input logic RESETN,
  // Register bus
  input logic WB_CYC_I,
  input logic WB_STB_I,
  input logic WB_WE_I,
  input logic [7:0] WB_ADR_I,
  input logic [31:0] WB_DAT_O,
  input logic WB_ACK_O,
  // Memory port
  input logic MEM_REQ,
  input logic MEM_WE,
  input logic [15:0] MEM_ADDR,
  input logic [7:0] MEM_WDATA,
  input logic MEM_ACK
);
  // ------
  // One clock domain, one reset
  // ------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  a_reset_quiet: assert property ($rose(RESETN) |->
    !MEM_REQ && !WB_ACK_O && WB_DAT_O == 32'h0)
    else $error("outputs not idle after reset");
  a_vector_first: assert property ($rose(RESETN) |-> ##[0:2]
    (MEM_REQ && !MEM_WE && MEM_ADDR == VECTOR_ADDR))
    else $error("no vector fetch after reset");
  // High vector byte first, then the byte above it
  a_vector_pair: assert property (MEM_REQ && MEM_ACK && !MEM_WE &&
    MEM_ADDR == VECTOR_ADDR |-> ##[2:4]
    (MEM_REQ && MEM_ADDR == VECTOR_ADDR + 16'h1))
    else $error("vector low byte not fetched next");
  a_req_hold: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ &&
    $stable(MEM_ADDR) && $stable(MEM_WE) && $stable(MEM_WDATA))
    else $error("memory request changed before answer");
  a_req_drop: assert property (MEM_ACK |=> !MEM_REQ)
    else $error("memory request held after answer");
  a_wb_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O
    |=> WB_ACK_O)
    else $error("bus request not answered next cycle");
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("bus answer longer than one cycle");
  // Nothing lives above the last mapped word
  a_unmapped_zero: assert property (WB_CYC_I && WB_STB_I &&
    !WB_WE_I && !WB_ACK_O && WB_ADR_I[7:2] > 6'h0a |=> WB_DAT_O == 32'h0)
    else $error("unmapped read not zero");
endmodule

bind cpu_addr_core cpu_addr_core_checker #(.VECTOR_ADDR(VECTOR_ADDR))
  chk_i (.CLK, .RESETN, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I,
  .WB_DAT_O, .WB_ACK_O, .MEM_REQ, .MEM_WE, .MEM_ADDR, .MEM_WDATA,
  .MEM_ACK);

/* sim/mem_model.sv */
// Byte-wide memory standing on the core's internal bus
`timescale 1ns/10ps
module mem_model (
  // Clock
  input logic clk,
  // Request from the core
  input logic req,
  input logic we,
  input logic [15:0] addr,
  input logic [7:0] wdata,
  // Answer delay in cycles, set by the bench
  input logic [1:0] lag,
  // Answer
  output logic [7:0] rdata,
  output logic ack
);
  logic [7:0] mem [0:65535]; // Whole byte address space
  logic [1:0] cnt = 2'h0; // Cycles waited so far
  initial begin
    ack = 1'b0;
    rdata = 8'h00;
    foreach (mem[i]) mem[i] = 8'h00;
  end
  // One request at a time; the data line never keeps a stale byte
  always @(posedge clk) begin
    ack <= 1'b0;
    rdata <= ~rdata;
    if (req && !ack) begin
      if (cnt == lag) begin
        cnt <= 2'h0;
        ack <= 1'b1;
        if (we) mem[addr] <= wdata;
        else rdata <= mem[addr];
      end else cnt <= cnt + 2'h1;
    end
  end
endmodule

/* sim/cpu_addr_core_tb.sv */
// Self-checking bench for the register set and address generator
`timescale 1ns/10ps
module cpu_addr_core_tb;
  // ------
  // Signals and bench state
  // ------
  logic CLK, RESETN, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
  logic MEM_REQ, MEM_WE, MEM_ACK;
  logic [7:0] WB_ADR_I, MEM_WDATA, MEM_RDATA;
  logic [3:0] WB_SEL_I;
  logic [31:0] WB_DAT_I, WB_DAT_O, q;
  logic [15:0] MEM_ADDR;
  logic [1:0] lag; // Memory answer delay
  int n_errors = 0;
  int total_checks = 0;
  // Code bytes at 2001, expected EA, expected X afterwards
  localparam logic [63:0] ROWS [15] = '{
    64'h30450000_0045_3000,
    64'h40123400_1234_3000,
    64'h70100000_2ff0_3000,
    64'h70e90000_3f01_3000,
    64'h70e21234_4234_3000,
    64'h70f50000_5002_3000,
    64'h70e60000_3102_3000,
    64'h70ec0000_4002_3000,
    64'h70c50000_2008_3000,
    64'h70280000_2ff8_2ff8,
    64'h70370000_3000_3008,
    64'h70e70000_5a6b_3000,
    64'h70e30010_7788_3000,
    64'h50fe0000_2001_3000,
    64'h60fffe00_2002_3000};

  cpu_addr_core dut (.CLK, .RESETN, .WB_CYC_I, .WB_STB_I, .WB_WE_I,
    .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .MEM_REQ,
    .MEM_WE, .MEM_ADDR, .MEM_WDATA, .MEM_RDATA, .MEM_ACK);
  mem_model mem_i (.clk(CLK), .req(MEM_REQ), .we(MEM_WE),
    .addr(MEM_ADDR), .wdata(MEM_WDATA), .lag(lag), .rdata(MEM_RDATA),
    .ack(MEM_ACK));

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  // ------
  // Tasks
  // ------
  task tally_and_finish;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] e);
    total_checks++;
    if (got !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, got);
    end
  endtask
  // One classic bus cycle; read data lands in q
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= w;
    WB_ADR_I <= a;
    WB_SEL_I <= 4'h3;
    WB_DAT_I <= d;
    do begin
      @(posedge CLK);
      n++;
    end while (WB_ACK_O !== 1'b1 && n < 40);
    q = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    if (n >= 40) begin
      n_errors++;
      tally_and_finish;
    end
  endtask
  // Poll busy until clear, bounded
  task idle;
    int n;
    n = 0;
    do begin
      wb(1'b0, 8'h04, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 60);
    if (n >= 60) begin
      n_errors++;
      tally_and_finish;
    end
  endtask
  // Place code at an odd address, point PC there, decode once
  task exec(input logic [31:0] b);
    for (int i = 0; i < 4; i++) mem_i.mem[16'h2001 + i] = b[31 - 8*i -: 8];
    wb(1'b1, 8'h18, 32'h2001);
    wb(1'b1, 8'h00, 32'h1);
    idle;
  endtask

  // ------
  // Main sequence
  // ------
  initial begin
    {RESETN, WB_CYC_I, WB_STB_I, WB_WE_I} = 4'h0;
    {WB_ADR_I, WB_SEL_I, WB_DAT_I} = 44'h0;
    lag = 2'h0;
    repeat (20) @(posedge CLK);
    {mem_i.mem[16'hfffe], mem_i.mem[16'hffff]} = 16'h2001;
    {mem_i.mem[16'h3102], mem_i.mem[16'h3103]} = 16'h5a6b;
    {mem_i.mem[16'h3010], mem_i.mem[16'h3011]} = 16'h7788;
    RESETN <= 1'b1;
    idle;
    wb(1'b0, 8'h18, 32'h0);
    chk("vector pc", q, 32'h2001);
    wb(1'b0, 8'h1c, 32'h0);
    chk("reset flags", q, 32'hd0);
    for (int i = 0; i < 15; i++) begin
      lag <= 2'(i);
      wb(1'b1, 8'h08, 32'h0102);
      wb(1'b1, 8'h0c, 32'h3000);
      wb(1'b1, 8'h10, 32'h4001);
      wb(1'b1, 8'h14, 32'h5000);
      exec(ROWS[i][63:32]);
      wb(1'b0, 8'h20, 32'h0);
      chk("ea", q, {16'h0, ROWS[i][31:16]});
      wb(1'b0, 8'h0c, 32'h0);
      chk("x", q, {16'h0, ROWS[i][15:0]});
    end
    lag <= 2'h3;
    exec(32'h20abcd00);
    wb(1'b0, 8'h24, 32'h0);
    chk("imm16", q, 32'habcd);
    wb(1'b0, 8'h18, 32'h0);
    chk("pc len3", q, 32'h2004);
    exec(32'h107e0000);
    wb(1'b0, 8'h24, 32'h0);
    chk("imm8", q, 32'h7e);
    exec(32'h00000000);
    wb(1'b0, 8'h18, 32'h0);
    chk("pc len1", q, 32'h2002);
    exec(32'h18000000);
    wb(1'b0, 8'h04, 32'h0);
    chk("page2", {31'h0, q[1]}, 32'h1);
    exec(32'h80123400);
    wb(1'b0, 8'h14, 32'h0);
    chk("sp push", q, 32'h4ffe);
    chk("push", {mem_i.mem[16'h4ffe], mem_i.mem[16'h4fff]}, 32'h2004);
    wb(1'b0, 8'h18, 32'h0);
    chk("call pc", q, 32'h1234);
    wb(1'b1, 8'h1c, 32'h04);
    exec(32'h51fe0000);
    wb(1'b0, 8'h18, 32'h0);
    chk("beq", q, 32'h2001);
    exec(32'h52fe0000);
    wb(1'b0, 8'h18, 32'h0);
    chk("bne", q, 32'h2003);
    wb(1'b1, 8'h1c, 32'h0b);
    exec(32'h53fe0000);
    wb(1'b0, 8'h18, 32'h0);
    chk("bcs", q, 32'h2001);
    exec(32'h57fe0000);
    wb(1'b0, 8'h18, 32'h0);
    chk("blt", q, 32'h2003);
    wb(1'b1, 8'h40, 32'hffff);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", q, 32'h0);
    RESETN <= 1'b0;
    repeat (2) @(posedge CLK);
    RESETN <= 1'b1;
    idle;
    wb(1'b0, 8'h1c, 32'h0);
    chk("flags again", q, 32'hd0);
    wb(1'b0, 8'h18, 32'h0);
    chk("pc again", q, 32'h2001);
    tally_and_finish;
  end
endmodule
